// [logic/sfr_bank_pkg.sv]
// Shared constants for the special-function register bank.
package sfr_bank_pkg;

  // ********************************
  // Register indices (byte address is four times the index)
  // ********************************
  localparam logic [7:0] IDX_BIT_OP   = 8'h00;
  localparam logic [7:0] IDX_PORT0    = 8'h80;
  localparam logic [7:0] IDX_STACK    = 8'h81;
  localparam logic [7:0] IDX_MODE0A   = 8'h84;
  localparam logic [7:0] IDX_MODE0B   = 8'h85;
  localparam logic [7:0] IDX_KEYPAD   = 8'h86;
  localparam logic [7:0] IDX_PWR      = 8'h87;
  localparam logic [7:0] IDX_TCTL     = 8'h88;
  localparam logic [7:0] IDX_TMODE    = 8'h89;
  localparam logic [7:0] IDX_T0LO     = 8'h8a;
  localparam logic [7:0] IDX_T1LO     = 8'h8b;
  localparam logic [7:0] IDX_T0HI     = 8'h8c;
  localparam logic [7:0] IDX_T1HI     = 8'h8d;
  localparam logic [7:0] IDX_PORT1    = 8'h90;
  localparam logic [7:0] IDX_MODE1A   = 8'h91;
  localparam logic [7:0] IDX_MODE1B   = 8'h92;
  localparam logic [7:0] IDX_DIVIDER  = 8'h95;
  localparam logic [7:0] IDX_SCTL     = 8'h98;
  localparam logic [7:0] IDX_SBUFFER  = 8'h99;
  localparam logic [7:0] IDX_PORT2    = 8'ha0;
  localparam logic [7:0] IDX_MODE2A   = 8'ha4;
  localparam logic [7:0] IDX_MODE2B   = 8'ha5;
  localparam logic [7:0] IDX_WD_FEED  = 8'ha6;
  localparam logic [7:0] IDX_WD_CTL   = 8'ha7;
  localparam logic [7:0] IDX_STATION  = 8'ha9;
  localparam logic [7:0] IDX_SMASK    = 8'hb9;
  localparam logic [7:0] IDX_STATUS   = 8'hd0;
  localparam logic [7:0] IDX_DIG_DIS  = 8'hf6;
  localparam logic [7:0] IDX_IPRIO_B  = 8'hf7;

  // ********************************
  // Reset values and implemented-bit masks
  // ********************************
  localparam logic [7:0] STACK_RESET    = 8'h07;
  localparam logic [7:0] MASK_MODE1     = 8'hd3;
  localparam logic [7:0] MASK_PORT2     = 8'h03;
  localparam logic [7:0] MASK_WD_CTL    = 8'h3f;
  localparam logic [7:0] WD_CTL_WDT_RST = 8'h3d;
  localparam logic [7:0] WD_CTL_ENABLED = 8'h1d;
  localparam logic [7:0] WD_CTL_OFF     = 8'h0d;
  localparam int         PWR_BROWNOUT   = 5;
  localparam int         PWR_POWER_ON   = 4;

  // ********************************
  // Bit operation register fields
  // ********************************
  localparam int         BIT_OP_POS  = 8;
  localparam int         BIT_VAL_POS = 16;
  localparam logic [1:0] BIT_OP_SET  = 2'h1;
  localparam logic [1:0] BIT_OP_CLR  = 2'h2;

  // ********************************
  // Machine cycle timing
  // ********************************
  localparam logic [3:0] FAST_CYCLE_CLOCKS     = 4'h6;
  localparam logic [3:0] STANDARD_CYCLE_CLOCKS = 4'hc;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [logic/pin_input_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_input_sync
  import sfr_bank_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;

  // A bit counts only once the last two stages agree, which hides a
  // metastable settle in the second stage from the register bank.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_one   <= '0;
      stage_two   <= '0;
      stage_three <= '0;
      synced      <= '0;
    end
    else
    begin
      stage_one   <= pins;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage_two[i] == stage_three[i])
        begin
          synced[i] <= stage_three[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/machine_cycle_timer.sv]
// CPU clock divider and machine cycle generator.
`timescale 1ns/100ps
`default_nettype none
module machine_cycle_timer
  import sfr_bank_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] divider,
  input  wire logic       standard_timing_select,
  output logic            cpu_clock_enable,
  output logic            machine_cycle_enable,
  output logic [3:0]      cycle_phase
);
  logic [7:0] divide_count;
  logic [3:0] cycle_length;
  logic       tick;

  assign cycle_length = standard_timing_select ? STANDARD_CYCLE_CLOCKS
                                               : FAST_CYCLE_CLOCKS;
  assign tick         = divide_count >= divider;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divide_count     <= '0;
      cpu_clock_enable <= 1'b0;
    end
    else if (tick)
    begin
      divide_count     <= '0;
      cpu_clock_enable <= 1'b1;
    end
    else
    begin
      divide_count     <= divide_count + 8'h01;
      cpu_clock_enable <= 1'b0;
    end
  end

  // Phase moves on the divider tick itself, so a machine cycle pulse
  // always coincides with a CPU clock pulse.
  // six or twelve CPU clock cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cycle_phase          <= '0;
      machine_cycle_enable <= 1'b0;
    end
    else if (tick)
    begin
      machine_cycle_enable <= (cycle_phase == cycle_length - 4'h1);
      cycle_phase <= (cycle_phase >= cycle_length - 4'h1) ? 4'h0 : cycle_phase + 4'h1;
    end
    else
    begin
      machine_cycle_enable <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [logic/sfr_bank_reset_and_cycle.sv]
// Special-function register bank with AXI4-Lite access and cycle timing.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Unimplemented register bits read back with no meaning attached.
// - Unused bits count as zero in listed reset values.
// - Port latches reset to the pin reset level configuration bit.
// - Any reset clears power control low nibble; brownout and power-on flags kept.
// - Power-on flag is set by hardware at supply power up.
// - Brownout flag is set on brownout events and at power up.
// - Watchdog control resets to one of three values by cause and enable.
// - Serial buffer is never initialised by reset.
// - Timer control holds overflow, run, edge and type bits.
// - Ports, status word, serial and timer control allow single-bit access.
// - Watchdog control holds six low bits, top two unused.
// - Port 0 input disable resets to zero, one bit per pin.
// - Port 0 reads return zero on disabled input pins.
// - A machine cycle is six oscillator periods by default.
// - Most instructions take six or twelve CPU clocks.
// - Standard timing option makes a machine cycle twelve periods.
// - CPU clock comes through a programmable divider.
// - Power control holds serial mode, flags, power-down and idle bits.
// - Port 2 mode one holds drive selects, clock output, toggle enables, pin modes.
module sfr_bank_reset_and_cycle
  import sfr_bank_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_on_rst_n,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_zero_pins,
  input  wire logic [7:0]  port_one_pins,
  input  wire logic [7:0]  port_two_pins,
  input  wire logic        brownout_event,
  input  wire logic        watchdog_reset_cause,
  input  wire logic        watchdog_enabled_config,
  input  wire logic        pin_reset_level_select,
  input  wire logic        standard_timing_select,
  output logic [7:0]       port_zero_latch,
  output logic [7:0]       port_one_latch,
  output logic [7:0]       port_two_latch,
  output logic [7:0]       power_control,
  output logic [7:0]       timer_control,
  output logic [7:0]       watchdog_control,
  output logic [7:0]       port_two_mode_one,
  output logic [7:0]       port_zero_input_disable,
  output logic             watchdog_feed_pulse,
  output logic             cpu_clock_enable,
  output logic             machine_cycle_enable
);

  // ********************************
  // Decode helpers
  // ********************************
  function automatic logic is_mapped(input logic [7:0] idx);
    unique case (idx)
      IDX_PORT0, IDX_STACK, IDX_MODE0A, IDX_MODE0B, IDX_KEYPAD, IDX_PWR, IDX_TCTL,
      IDX_TMODE, IDX_T0LO, IDX_T1LO, IDX_T0HI, IDX_T1HI, IDX_PORT1, IDX_MODE1A,
      IDX_MODE1B, IDX_DIVIDER, IDX_SCTL, IDX_SBUFFER, IDX_PORT2, IDX_MODE2A,
      IDX_MODE2B, IDX_WD_FEED, IDX_WD_CTL, IDX_STATION, IDX_SMASK, IDX_STATUS,
      IDX_DIG_DIS, IDX_IPRIO_B, IDX_BIT_OP:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // Unused positions are never stored, so they read as zero and also
  // count as zero in every reset value.
  function automatic logic [7:0] used_bits(input logic [7:0] idx);
    unique case (idx)
      IDX_MODE1A, IDX_MODE1B:
        used_bits = MASK_MODE1;
      IDX_PORT2, IDX_MODE2B:
        used_bits = MASK_PORT2;
      IDX_WD_CTL:
        used_bits = MASK_WD_CTL;
      default:
        used_bits = 8'hff;
    endcase
  endfunction

  function automatic logic bit_addressable(input logic [7:0] idx);
    bit_addressable = (idx == IDX_PORT0) || (idx == IDX_PORT1) || (idx == IDX_PORT2) ||
                      (idx == IDX_STATUS) || (idx == IDX_SCTL) || (idx == IDX_TCTL);
  endfunction

  // ********************************
  // Reset release and input synchronisers
  // ********************************
  logic        rst_meta_n;
  logic        rst_sync_n;
  logic [24:0] synced;
  logic [7:0]  pin_zero;
  logic [7:0]  pin_one;
  logic [7:0]  pin_two;
  logic        brownout_seen;
  logic        brownout_prev;
  logic        init_pending;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  pin_input_sync #(
    .WIDTH (25)
  ) i_pin_input_sync (
    .clk    (clk),
    .rst_n  (rst_sync_n),
    .pins   ({brownout_event, port_two_pins, port_one_pins, port_zero_pins}),
    .synced (synced)
  );

  assign pin_zero      = synced[7:0];
  assign pin_one       = synced[15:8];
  assign pin_two       = synced[23:16];
  assign brownout_seen = synced[24] && !brownout_prev;

  // ********************************
  // AXI4-Lite write channel
  // ********************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_index;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        write_fire;
  logic        write_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign write_fire    = aw_held && w_held && !s_axi_bvalid;
  assign write_ok      = is_mapped(aw_index) && w_strb[0];

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_index     <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held  <= 1'b1;
        aw_index <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (write_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_index) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************
  // Register storage
  // ********************************
  logic [7:0] regs [128];
  logic [7:0] serial_buffer;
  logic [7:0] bit_address;
  logic [7:0] bit_byte;
  logic [7:0] bit_mask;
  logic [7:0] next_bit_address;
  logic [1:0] bit_op;
  logic       bit_write;
  logic       byte_write;
  logic       brownout_flag;
  logic       power_on_flag;

  assign bit_op           = w_data[BIT_OP_POS+1:BIT_OP_POS];
  assign next_bit_address = w_data[7:0];
  assign bit_byte         = {next_bit_address[7:3], 3'h0};
  assign bit_mask         = used_bits(bit_byte);
  assign byte_write       = write_fire && write_ok && aw_index[7];
  assign bit_write        = write_fire && write_ok && (aw_index == IDX_BIT_OP) &&
                            next_bit_address[7] && bit_addressable(bit_byte) &&
                            (bit_op == BIT_OP_SET || bit_op == BIT_OP_CLR);

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int i = 0; i < 128; i++)
      begin
        regs[i] <= 8'h00;
      end
      regs[IDX_STACK[6:0]] <= STACK_RESET;
      init_pending         <= 1'b1;
    end
    else if (init_pending)
    begin
      init_pending <= 1'b0;
      regs[IDX_PORT0[6:0]] <= {8{pin_reset_level_select}};
      regs[IDX_PORT1[6:0]] <= {8{pin_reset_level_select}};
      regs[IDX_PORT2[6:0]] <= {8{pin_reset_level_select}} & MASK_PORT2;
      if (watchdog_reset_cause)
      begin
        regs[IDX_WD_CTL[6:0]] <= WD_CTL_WDT_RST;
      end
      else if (watchdog_enabled_config)
      begin
        regs[IDX_WD_CTL[6:0]] <= WD_CTL_ENABLED;
      end
      else
      begin
        regs[IDX_WD_CTL[6:0]] <= WD_CTL_OFF;
      end
    end
    else if (byte_write && aw_index != IDX_SBUFFER && aw_index != IDX_WD_FEED)
    begin
      regs[aw_index[6:0]] <= w_data[7:0] & used_bits(aw_index);
    end
    else if (bit_write)
    begin
      regs[bit_byte[6:0]][next_bit_address[2:0]] <= (bit_op == BIT_OP_SET) &&
                                                    bit_mask[next_bit_address[2:0]];
    end
  end

  always_ff @(posedge clk)
  begin
    if (byte_write && aw_index == IDX_SBUFFER)
    begin
      serial_buffer <= w_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      bit_address <= '0;
    end
    else if (write_fire && write_ok && aw_index == IDX_BIT_OP)
    begin
      bit_address <= next_bit_address;
    end
  end

  // ********************************
  // Power flags kept across ordinary resets
  // ********************************
  // These flags see only the power-up reset, which sets them, so a brownout or watchdog reset
  // leaves the cause visible to software afterwards.
  always_ff @(posedge clk or negedge power_on_rst_n)
  begin
    if (!power_on_rst_n)
    begin
      power_on_flag <= 1'b1;
      brownout_flag <= 1'b1;
      brownout_prev <= 1'b0;
    end
    else
    begin
      brownout_prev <= synced[24];
      if (brownout_seen)
      begin
        brownout_flag <= 1'b1;
      end
      else if (byte_write && aw_index == IDX_PWR)
      begin
        brownout_flag <= w_data[PWR_BROWNOUT];
      end
      else if (bit_write && bit_byte == IDX_PWR && next_bit_address[2:0] == 3'h5)
      begin
        brownout_flag <= bit_op == BIT_OP_SET;
      end
      if (byte_write && aw_index == IDX_PWR)
      begin
        power_on_flag <= w_data[PWR_POWER_ON];
      end
    end
  end

  // ********************************
  // Outputs and read path
  // ********************************
  logic [7:0] read_byte;
  logic [7:0] ar_index;
  logic [7:0] ar_bit_byte;

  assign power_control = {regs[IDX_PWR[6:0]][7:6], brownout_flag, power_on_flag,
                          regs[IDX_PWR[6:0]][3:0]};
  assign timer_control           = regs[IDX_TCTL[6:0]];
  assign port_zero_latch         = regs[IDX_PORT0[6:0]];
  assign port_one_latch          = regs[IDX_PORT1[6:0]];
  assign port_two_latch          = regs[IDX_PORT2[6:0]];
  assign watchdog_control        = regs[IDX_WD_CTL[6:0]];
  assign port_two_mode_one       = regs[IDX_MODE2A[6:0]];
  assign port_zero_input_disable = regs[IDX_DIG_DIS[6:0]];
  assign ar_index                = s_axi_araddr[9:2];
  assign ar_bit_byte             = {bit_address[7:3], 3'h0};

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      watchdog_feed_pulse <= 1'b0;
    end
    else
    begin
      watchdog_feed_pulse <= byte_write && aw_index == IDX_WD_FEED;
    end
  end

  always_comb
  begin
    read_byte = 8'h00;
    unique case (ar_index)
      IDX_PORT0:
        read_byte = pin_zero & ~regs[IDX_DIG_DIS[6:0]];
      IDX_PORT1:
        read_byte = pin_one;
      IDX_PORT2:
        read_byte = pin_two & MASK_PORT2;
      IDX_PWR:
        read_byte = power_control;
      IDX_SBUFFER:
        read_byte = serial_buffer;
      IDX_WD_FEED:
        read_byte = 8'h00;
      default:
        read_byte = ar_index[7] ? regs[ar_index[6:0]] : 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(ar_index) ? RESP_OKAY : RESP_SLVERR;
      if (ar_index == IDX_BIT_OP)
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rdata[7:0] <= bit_address;
        s_axi_rdata[BIT_VAL_POS] <= bit_address[7] &&
                                    regs[ar_bit_byte[6:0]][bit_address[2:0]];
      end
      else
      begin
        s_axi_rdata <= {24'h0, read_byte};
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ********************************
  // Machine cycle timing
  // ********************************
  machine_cycle_timer i_machine_cycle_timer (
    .clk                    (clk),
    .rst_n                  (rst_sync_n),
    .divider                (regs[IDX_DIVIDER[6:0]]),
    .standard_timing_select (standard_timing_select),
    .cpu_clock_enable       (cpu_clock_enable),
    .machine_cycle_enable   (machine_cycle_enable),
    .cycle_phase            ()
  );

endmodule
`default_nettype wire

// [bench/sfr_bank_sva.sv]
// Port-level concurrent checks for the register bank.
`timescale 1ns/100ps
`default_nettype none
module sfr_bank_sva
  import sfr_bank_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  power_control,
  input wire logic        watchdog_feed_pulse,
  input wire logic        cpu_clock_enable,
  input wire logic        machine_cycle_enable
);
  // ********************************
  // Bus, reset and timing relations
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_busy_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  a_upper_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:17] == 15'h0)
    else $error("unused read bits set");
  a_power_low_reset: assert property ($rose(rst_n) |-> power_control[3:0] == 4'h0)
    else $error("power control low bits kept");
  a_feed_single: assert property (watchdog_feed_pulse |=> !watchdog_feed_pulse)
    else $error("feed pulse too long");
  a_cycle_on_cpu: assert property (machine_cycle_enable |-> cpu_clock_enable)
    else $error("machine cycle off cpu clock");
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_feed: cover property (watchdog_feed_pulse);
  c_cycle: cover property (machine_cycle_enable);
endmodule
`default_nettype wire

// [bench/sfr_bank_reset_and_cycle_test.sv]
// Self-checking bench for the register bank.
`timescale 1ns/100ps
`default_nettype none
module sfr_bank_reset_and_cycle_test;
  import sfr_bank_pkg::*;
  // ********************************
  // Stimulus, bus tasks and tests
  // ********************************
  logic        clk = 1'b0, rst_n = 1'b0, power_on_rst_n = 1'b0;
  logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [7:0]  port_zero_pins = '0, port_one_pins = '0, port_two_pins = '0;
  logic        brownout_event = 0, watchdog_reset_cause = 0, watchdog_enabled_config = 0;
  logic        pin_reset_level_select = 0, standard_timing_select = 0;
  logic [7:0]  port_zero_latch, port_one_latch, port_two_latch, power_control;
  logic [7:0]  timer_control, watchdog_control, port_two_mode_one, port_zero_input_disable;
  logic        watchdog_feed_pulse, cpu_clock_enable, machine_cycle_enable;
  logic [7:0]  wd_exp [3] = '{WD_CTL_OFF, WD_CTL_ENABLED, WD_CTL_WDT_RST};
  logic [7:0]  bytes [6] = '{IDX_PORT0, IDX_TCTL, IDX_PORT1, IDX_SCTL, IDX_PORT2, IDX_STATUS};
  int          error_cnt = 0, compares = 0, cycles = 0, feeds = 0, per = 0;

  sfr_bank_reset_and_cycle i_sfr_bank_reset_and_cycle (.*);

  always #2 clk = ~clk;

  // The ceiling is several times the full run, so only a hang reaches it.
  always @(posedge clk)
  begin
    cycles++;
    if (watchdog_feed_pulse === 1'b1) feeds++;
    if (cycles == 5000)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] idx, input logic [31:0] data);
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] idx);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    power_on_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    do_reset();
    check_byte(power_control, 8'h30, "power-up flags");
    axi_read(IDX_STACK);
    check_byte(rd[7:0], STACK_RESET, "stack pointer");
    axi_read(IDX_DIG_DIS);
    check_byte(rd[7:0], 8'h00, "disable reset");
    axi_read(8'hc0);
    check_byte({6'h00, rr}, {6'h00, RESP_SLVERR}, "unmapped resp");
    check_byte(rd[7:0], 8'h00, "unmapped data");
    axi_write(8'hc0, 32'h00);
    check_byte({6'h00, rr}, {6'h00, RESP_SLVERR}, "unmapped write resp");
    axi_write(IDX_WD_CTL, 32'h3f);
    check_byte(watchdog_control, MASK_WD_CTL, "watchdog bits");
    axi_write(IDX_SBUFFER, 32'h3c);
    axi_read(IDX_SBUFFER);
    check_byte(rd[7:0], 8'h3c, "serial buffer");
    $display("test done: reset and access");
    axi_write(IDX_PWR, 32'hff);
    check_byte(power_control, 8'hff, "power write");
    for (int k = 0; k < 3; k++)
    begin
      watchdog_reset_cause <= (k == 2);
      watchdog_enabled_config <= (k == 1);
      pin_reset_level_select <= k[0];
      do_reset();
      check_byte(power_control, 8'h30, "power after reset");
      check_byte(watchdog_control, wd_exp[k], "watchdog reset");
      check_byte(port_zero_latch, {8{k[0]}}, "port zero level");
      check_byte(port_one_latch, {8{k[0]}}, "port level");
      check_byte(port_two_latch, {8{k[0]}} & MASK_PORT2, "port two level");
    end
    axi_write(IDX_PWR, 32'h00);
    check_byte(power_control, 8'h00, "flags cleared");
    brownout_event <= 1'b1;
    repeat (8) @(posedge clk);
    brownout_event <= 1'b0;
    check_byte(power_control, 8'h20, "brownout flag");
    $display("test done: power and reset causes");
    port_zero_pins <= 8'ha5;
    port_one_pins <= 8'h5a;
    port_two_pins <= 8'hff;
    axi_write(IDX_DIG_DIS, 32'h0f);
    check_byte(port_zero_input_disable, 8'h0f, "disable reg");
    repeat (6) @(posedge clk);
    axi_read(IDX_PORT0);
    check_byte(rd[7:0], 8'ha0, "port zero read");
    axi_read(IDX_PORT1);
    check_byte(rd[7:0], 8'h5a, "port one read");
    axi_read(IDX_PORT2);
    check_byte(rd[7:0], MASK_PORT2, "port two read");
    axi_write(IDX_MODE2A, 32'hff);
    check_byte(port_two_mode_one, 8'hff, "mode one");
    $display("test done: ports");
    foreach (bytes[i])
    begin
      axi_write(IDX_BIT_OP, {22'h0, BIT_OP_SET, bytes[i] | 8'h01});
      axi_read(IDX_BIT_OP);
      check_byte(rd[7:0], bytes[i] | 8'h01, "bit select");
      check_byte(rd[23:16], 8'h01, "bit set");
      if (i == 1) check_byte(timer_control, 8'h02, "edge flag");
      axi_write(IDX_BIT_OP, {22'h0, BIT_OP_CLR, bytes[i] | 8'h01});
      axi_read(IDX_BIT_OP);
      check_byte(rd[23:16], 8'h00, "bit clear");
    end
    $display("test done: bit access");
    axi_write(IDX_WD_FEED, 32'h00);
    repeat (3) @(posedge clk);
    check_byte(feeds[7:0], 8'h01, "feed pulse");
    $display("test done: feed");
    for (int m = 0; m < 4; m++)
    begin
      standard_timing_select <= m[0];
      axi_write(IDX_DIVIDER, {30'h0, m[1], 1'b0});
      for (int p = 0; p < 3; p++)
      begin
        per = 0;
        do
        begin
          @(posedge clk);
          per++;
        end while (machine_cycle_enable !== 1'b1);
      end
      check_byte(per[7:0], (m[0] ? 8'h0c : 8'h06) * (m[1] ? 8'h03 : 8'h01), "cycle");
    end
    $display("test done: timing");
    give_verdict();
  end
endmodule

bind sfr_bank_reset_and_cycle sfr_bank_sva i_sfr_bank_sva (.*);
`default_nettype wire
